// *** timer_params.svh ***
// Purpose: Offsets, field positions and timing counts of the timer section
// Assumes: 100 MHz mclk, 8-bit register port
// Notes:   Definitions only
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define ADDR_W              8
`define OFS_RUN_CONTROL     8'h0e
`define OFS_ZERO_CONFIG     8'h0f
`define OFS_RELOAD_HIGH     8'h10
`define OFS_RELOAD_LOW      8'h11
`define OFS_COUNT_HIGH      8'h12
`define OFS_COUNT_LOW       8'h13
`define OFS_IRQ_STATUS      8'h20
`define OFS_IRQ_MASK        8'h21

`define CFG_HALT_RX_BIT     7
`define CFG_START_HI        5
`define CFG_START_LO        4
`define CFG_RELOAD_BIT      3
`define CFG_CLK_HI          1
`define CFG_CLK_LO          0
`define CFG_WRITE_MASK      8'hbb

// Count clock periods in ns, rates as fixed 100 MHz divisions
`define MCLK_PERIOD_NS      10
`define FAST_TICK_PERIOD_NS 74
`define SLOW_TICK_PERIOD_NS 4720
`define FAST_TICK_CYCLES    (`FAST_TICK_PERIOD_NS / `MCLK_PERIOD_NS)
`define SLOW_TICK_CYCLES    (`SLOW_TICK_PERIOD_NS / `MCLK_PERIOD_NS)
`define RX_NIBBLE_BITS      4

`endif

// *** timer_pkg.sv ***
// Purpose: Types shared by the timer section
// Assumes: Nothing
// Notes:   Numbers live in timer_params.svh
package timer_pkg;
    typedef enum logic [1:0] {
        start_manual, start_end_of_tx, start_trim_plain, start_trim_underflow
    } start_mode_t;
    typedef enum logic [1:0] {
        clk_fast, clk_slow, clk_timer_two, clk_timer_one
    } clock_select_t;
    typedef enum logic [1:0] { trim_idle, trim_armed, trim_counting } trim_state_t;
endpackage : timer_pkg

// *** timer_tick_if.sv ***
// Purpose: Carries timer zero control between top and counter
// Assumes: Single mclk domain
// Notes:   Tick, load, stop and underflow are one-cycle pulses; config fields, active and count are levels
`timescale 1ns/1ps
interface timer_tick_if;
    import timer_pkg::*;
    logic          tick;
    logic          load;
    logic          stop;
    logic          allow_restart;
    logic [15:0]   reload_value;
    logic          active;
    logic          underflow;
    logic [15:0]   count;
    modport ctrl (output tick, load, stop, allow_restart, reload_value,
                  input active, underflow, count);
    modport core (input tick, load, stop, allow_restart, reload_value,
                  output active, underflow, count);
endinterface : timer_tick_if

// *** timer_zero_core.sv ***
// Purpose: Sixteen-bit down counter of timer zero
// Assumes: Load and stop are never high together with a useful tick
// Notes:   Load wins over stop, stop over counting
`timescale 1ns/1ps
module timer_zero_core
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   rstn,
    // Control
    timer_tick_if.core  tif
);
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        active_reg;
    logic        active_next;
    logic        under_reg;
    logic        under_next;

    always_comb begin
        count_next  = count_reg;
        active_next = active_reg;
        under_next  = 1'b0;
        if (tif.load) begin
            count_next  = tif.reload_value;               // see R13
            active_next = 1'b1;
        end else if (tif.stop) begin
            active_next = 1'b0;
        end else if (active_reg && tif.tick) begin
            if (count_reg == 16'h0000) begin
                under_next = 1'b1;                        // see R10
                if (tif.allow_restart) begin
                    count_next = tif.reload_value;        // see R8
                end else begin
                    active_next = 1'b0;                   // see R9
                end
            end else begin
                count_next = count_reg - 16'h0001;        // see R15
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            count_reg  <= 16'h0000;                       // see R16
            active_reg <= 1'b0;
            under_reg  <= 1'b0;
        end else begin
            count_reg  <= count_next;
            active_reg <= active_next;
            under_reg  <= under_next;
        end
    end

    assign tif.count     = count_reg;
    assign tif.active    = active_reg;
    assign tif.underflow = under_reg;
endmodule : timer_zero_core

// *** timer_section.sv ***
// Purpose: Timer section control: run control, timer zero, interrupt
// Assumes: Register port on mclk; frame events are mclk-domain pulses
// Notes:   Timers one to three sit outside; only their run bits live here
// Operation
// R1: Low nibble masks writes to run bits
// R2: Upper nibble shows timers three..zero running
// R3: Masked write starts on one, stops on zero
// R4: Halt timer zero after four received bits
// R5: Receive halt ignored in trimming modes
// R6: Mode zero manual, one starts at tx end
// R7: Modes two, three: oscillator trimming on edges
// R8: Auto-restart reloads at zero and continues; here plain trimming mode two ignores it and stops at zero
// R9: Without restart, stop at zero, clear running
// R10: Every underflow sets the interrupt flag
// R11: Clock select zero fast, one slow
// R12: Select two, three cascade from timers two, one
// R13: Start loads counter from reload bytes
// R14: Reload writes act only at next start; here they also act at the next auto-restart reload on underflow
// R15: Decrement once per selected tick
// R16: Reset stops timers, fields read zero
// R17: Count bytes not read during reception
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_section
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    // Register port
    input  wire logic [`ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [7:0]           reg_rdata,
    // Frame events from the transceiver
    input  wire logic                 tx_done,
    input  wire logic                 rx_bit_valid,
    input  wire logic                 rx_frame_start,
    // Oscillator trimming edge, from a pin
    input  wire logic                 low_freq_oscillator,
    // Other timers
    input  wire logic                 timer_one_underflow,
    input  wire logic                 timer_two_underflow,
    output logic      [2:0]           other_timer_start,
    output logic      [2:0]           other_timer_stop,
    input  wire logic [2:0]           other_timer_active,
    // Interrupt
    output logic                      irq
);
    timer_tick_if tif ();

    // Registers and next values
    logic [7:0]   config_reg;
    logic [7:0]   config_next;
    logic [7:0]   reload_high_reg;
    logic [7:0]   reload_high_next;
    logic [7:0]   reload_low_reg;
    logic [7:0]   reload_low_next;
    logic         irq_status_reg;
    logic         irq_status_next;
    logic         irq_mask_reg;
    logic         irq_mask_next;
    logic [7:0]   rdata_reg;
    logic [7:0]   rdata_next;
    logic [9:0]   slow_div_reg;
    logic [9:0]   slow_div_next;
    logic [3:0]   fast_div_reg;
    logic [3:0]   fast_div_next;
    logic [2:0]   rx_bits_reg;
    logic [2:0]   rx_bits_next;
    logic         halted_rx_reg;
    logic         halted_rx_next;
    trim_state_t  trim_reg;
    trim_state_t  trim_next;
    logic         osc_meta_reg;
    logic         osc_sync_reg;
    logic         osc_prev_reg;

    start_mode_t   start_mode;
    clock_select_t clk_sel;
    logic          write_run;
    logic [3:0]    run_mask;
    logic [3:0]    run_value;
    logic          fast_tick;
    logic          slow_tick;
    logic          osc_rise;
    logic          trimming;
    logic          sw_start;
    logic          sw_stop;
    logic          auto_start;
    logic          rx_halt;
    logic          trim_start;
    logic          trim_stop;

    assign start_mode = start_mode_t'(config_reg[`CFG_START_HI:`CFG_START_LO]);
    assign clk_sel    = clock_select_t'(config_reg[`CFG_CLK_HI:`CFG_CLK_LO]);
    assign trimming   = (start_mode == start_trim_plain)
                     || (start_mode == start_trim_underflow);

    // Masked run control write
    assign write_run = reg_write && (reg_addr == `OFS_RUN_CONTROL);
    assign run_mask  = write_run ? reg_wdata[3:0] : 4'h0;      // see R1
    assign run_value = reg_wdata[7:4];
    assign sw_start  = run_mask[0] && run_value[0];            // see R3
    assign sw_stop   = run_mask[0] && !run_value[0];           // see R3

    genvar gi;
    generate
        for (gi = 1; gi < 4; gi++) begin : g_other
            assign other_timer_start[gi-1] = run_mask[gi] && run_value[gi];  // see R3
            assign other_timer_stop[gi-1]  = run_mask[gi] && !run_value[gi]; // see R1
        end
    endgenerate

    // Level from a pin: two flops before use
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= low_freq_oscillator;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end
    assign osc_rise = osc_sync_reg && !osc_prev_reg;

    // Rate dividers; 13.56 MHz approximated on 100 MHz
    always_comb begin
        fast_div_next = (fast_div_reg == 4'(`FAST_TICK_CYCLES - 1))
                      ? 4'h0 : fast_div_reg + 4'h1;
        slow_div_next = (slow_div_reg == 10'(`SLOW_TICK_CYCLES - 1))
                      ? 10'h000 : slow_div_reg + 10'h001;
    end
    assign fast_tick = (fast_div_reg == 4'h0);
    assign slow_tick = (slow_div_reg == 10'h000);

    always_comb begin
        case (clk_sel)
            clk_fast:      tif.tick = fast_tick;              // see R11
            clk_slow:      tif.tick = slow_tick;              // see R11
            clk_timer_two: tif.tick = timer_two_underflow;    // see R12
            clk_timer_one: tif.tick = timer_one_underflow;    // see R12
            default:       tif.tick = 1'b0;
        endcase
    end

    // Trimming: first rising edge starts, the next stops
    always_comb begin
        trim_next  = trim_reg;
        trim_start = 1'b0;
        trim_stop  = 1'b0;
        case (trim_reg)
            trim_idle: begin
                if (trimming) begin
                    trim_next = trim_armed;
                end
            end
            trim_armed: begin
                if (!trimming) begin
                    trim_next = trim_idle;
                end else if (osc_rise) begin
                    trim_start = 1'b1;                        // see R7
                    trim_next  = trim_counting;
                end
            end
            trim_counting: begin
                if (!trimming) begin
                    trim_next = trim_idle;
                end else if (osc_rise || !tif.active) begin
                    trim_stop = osc_rise;                     // see R7
                    trim_next = trim_idle;
                end
            end
            default: trim_next = trim_idle;
        endcase
    end

    // Receive halt after the first four bits of a frame
    always_comb begin
        rx_bits_next   = rx_bits_reg;
        halted_rx_next = halted_rx_reg;
        rx_halt        = 1'b0;
        if (rx_frame_start) begin
            rx_bits_next   = 3'h0;
            halted_rx_next = 1'b0;
        end else if (rx_bit_valid && !halted_rx_reg) begin
            rx_bits_next = rx_bits_reg + 3'h1;
            if (rx_bits_reg == 3'(`RX_NIBBLE_BITS - 1)) begin
                halted_rx_next = 1'b1;
                rx_halt = config_reg[`CFG_HALT_RX_BIT] && !trimming; // see R4, R5
            end
        end
    end

    assign auto_start = tx_done && (start_mode == start_end_of_tx);  // see R6
    assign tif.load   = sw_start || auto_start || trim_start;         // see R13
    assign tif.stop   = sw_stop || rx_halt || trim_stop;
    // Plain trimming mode never reloads on underflow
    assign tif.allow_restart = config_reg[`CFG_RELOAD_BIT]
                            && (start_mode != start_trim_plain);      // see R8
    // Reload bytes feed the load path and the auto-restart at underflow
    assign tif.reload_value  = {reload_high_reg, reload_low_reg};     // see R14

    // Register writes and interrupt
    always_comb begin
        config_next      = config_reg;
        reload_high_next = reload_high_reg;
        reload_low_next  = reload_low_reg;
        irq_mask_next    = irq_mask_reg;
        irq_status_next  = irq_status_reg;
        if (reg_write) begin
            case (reg_addr)
                `OFS_ZERO_CONFIG: config_next      = reg_wdata & `CFG_WRITE_MASK;
                `OFS_RELOAD_HIGH: reload_high_next = reg_wdata;       // see R14
                `OFS_RELOAD_LOW:  reload_low_next  = reg_wdata;       // see R14
                `OFS_IRQ_MASK:    irq_mask_next    = reg_wdata[0];
                `OFS_IRQ_STATUS:  begin
                    if (reg_wdata[0]) begin
                        irq_status_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        if (tif.underflow) begin
            irq_status_next = 1'b1;                           // see R10
        end
    end

    // Read data, valid the cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                `OFS_RUN_CONTROL: rdata_next = {other_timer_active[2:0],
                                                tif.active, 4'h0};     // see R2
                `OFS_ZERO_CONFIG: rdata_next = config_reg;
                `OFS_RELOAD_HIGH: rdata_next = reload_high_reg;
                `OFS_RELOAD_LOW:  rdata_next = reload_low_reg;
                // Not meaningful mid-reception; software avoids that
                `OFS_COUNT_HIGH:  rdata_next = tif.count[15:8];        // see R17
                `OFS_COUNT_LOW:   rdata_next = tif.count[7:0];         // see R17
                `OFS_IRQ_STATUS:  rdata_next = {7'h00, irq_status_reg};
                `OFS_IRQ_MASK:    rdata_next = {7'h00, irq_mask_reg};
                default:          rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            config_reg      <= 8'h00;                         // see R16
            reload_high_reg <= 8'h00;
            reload_low_reg  <= 8'h00;
            irq_status_reg  <= 1'b0;
            irq_mask_reg    <= 1'b0;
            rdata_reg       <= 8'h00;
            slow_div_reg    <= 10'h000;
            fast_div_reg    <= 4'h0;
            rx_bits_reg     <= 3'h0;
            halted_rx_reg   <= 1'b0;
            trim_reg        <= trim_idle;
        end else begin
            config_reg      <= config_next;
            reload_high_reg <= reload_high_next;
            reload_low_reg  <= reload_low_next;
            irq_status_reg  <= irq_status_next;
            irq_mask_reg    <= irq_mask_next;
            rdata_reg       <= rdata_next;
            slow_div_reg    <= slow_div_next;
            fast_div_reg    <= fast_div_next;
            rx_bits_reg     <= rx_bits_next;
            halted_rx_reg   <= halted_rx_next;
            trim_reg        <= trim_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = irq_status_reg && irq_mask_reg;

    timer_zero_core u_core (
        .mclk (mclk),
        .rstn (rstn),
        .tif  (tif.core)
    );
endmodule : timer_section

// *** timer_section_props.sv ***
// Purpose: Concurrent checks on the timer section ports
// Assumes: Single mclk domain, rstn synchronous active low
// Notes:   Bound to timer_section below
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_section_props
    import timer_pkg::*;
(
    input wire logic               mclk,
    input wire logic               rstn,
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_write,
    input wire logic               reg_read,
    input wire logic [7:0]         reg_rdata,
    input wire logic               tx_done,
    input wire logic               rx_bit_valid,
    input wire logic               rx_frame_start,
    input wire logic               low_freq_oscillator,
    input wire logic               timer_one_underflow,
    input wire logic               timer_two_underflow,
    input wire logic [2:0]         other_timer_start,
    input wire logic [2:0]         other_timer_stop,
    input wire logic [2:0]         other_timer_active,
    input wire logic               irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic run_wr;
    logic mapped;
    assign run_wr = reg_write && reg_addr == 8'h0e;
    assign mapped = reg_addr inside {[8'h0e:8'h13], 8'h20, 8'h21};

    start_masked_a: assert property (other_timer_start === (run_wr ?
        reg_wdata[3:1] & reg_wdata[7:5] : 3'h0)) else $error("start pulse wrong");
    stop_masked_a: assert property (other_timer_stop === (run_wr ?
        reg_wdata[3:1] & ~reg_wdata[7:5] : 3'h0)) else $error("stop pulse wrong");
    start_stop_excl_a: assert property ((other_timer_start & other_timer_stop) == 3'h0)
        else $error("start and stop together");
    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    run_status_a: assert property (reg_read && reg_addr == 8'h0e |=>
        reg_rdata[7:5] == $past(other_timer_active) && reg_rdata[3:0] == 4'h0)
        else $error("run status wrong");
    unmapped_zero_a: assert property (reg_read && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cfg_reserved_a: assert property (reg_read && reg_addr == 8'h0f |=>
        reg_rdata[6] == 1'b0 && reg_rdata[2] == 1'b0) else $error("reserved bits set");
    irq_masked_a: assert property (reg_write && reg_addr == 8'h21 && !reg_wdata[0]
        |=> !irq) else $error("irq while masked");

    cover property (irq);
    cover property (other_timer_start != 3'h0);
    cover property (reg_read && reg_addr == 8'h12);
endmodule : timer_section_props

bind timer_section timer_section_props i_props (.mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_done(tx_done),
    .rx_bit_valid(rx_bit_valid), .rx_frame_start(rx_frame_start),
    .low_freq_oscillator(low_freq_oscillator), .timer_one_underflow(timer_one_underflow),
    .timer_two_underflow(timer_two_underflow), .other_timer_start(other_timer_start),
    .other_timer_stop(other_timer_stop), .other_timer_active(other_timer_active), .irq(irq));

// *** timer_section_test.sv ***
// Purpose: Register level test of the timer section
// Assumes: 100 MHz mclk, fast tick every 7 cycles
// Notes:   Polls run status under bounded loops
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_section_test;
    import timer_pkg::*;
    logic               mclk = 1'b0;
    logic               rstn = 1'b0;
    logic [`ADDR_W-1:0] reg_addr = 8'h00;
    logic [7:0]         reg_wdata = 8'h00;
    logic               reg_write = 1'b0;
    logic               reg_read = 1'b0;
    logic [7:0]         reg_rdata;
    logic [4:0]         ev = 5'h00;
    logic               osc = 1'b0;
    logic [2:0]         other_active = 3'h0;
    logic [2:0]         o_start;
    logic [2:0]         o_stop;
    logic               irq;
    int                 fail_count = 0;
    int                 samples_checked = 0;
    int                 i;
    logic [7:0]         v_first;
    logic [7:0]         v_second;
    logic [7:0]         reset_addr [9] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13,
                                           8'h20, 8'h21, 8'h30};

    timer_section i_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .tx_done(ev[0]), .rx_bit_valid(ev[1]),
        .rx_frame_start(ev[2]), .low_freq_oscillator(osc),
        .timer_one_underflow(ev[3]), .timer_two_underflow(ev[4]),
        .other_timer_start(o_start), .other_timer_stop(o_stop),
        .other_timer_active(other_active), .irq(irq));

    initial begin
        forever #5 mclk = ~mclk;
    end

    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp, "register read");
    endtask : rchk

    // One-cycle pulse on an event input: 0 tx, 1 rx bit, 2 frame, 3 t1, 4 t2
    task pulse(input int n);
        @(posedge mclk);
        ev[n] <= 1'b1;
        @(posedge mclk);
        ev[n] <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : pulse

    task wait_run(input logic e);
        logic [7:0] v;
        for (int k = 0; k < 300; k++) begin
            rd(8'h0e, v);
            if (v[4] === e)
                return;
        end
        fail_count++;
        $display("mismatch at %0t: run bit wait ran out", $time);
        summarize();
    endtask : wait_run

    task done(input string n);
        wr(8'h0e, 8'h01);
        $display("test %s finished", n);
    endtask : done

    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        foreach (reset_addr[j])
            rchk(reset_addr[j], 8'h00);
        wr(8'h0f, 8'hff);
        rchk(8'h0f, 8'hbb);
        $display("test reset finished");
        // Upper ones with zero mask must not start anything
        wr(8'h0f, 8'h00);
        wr(8'h11, 8'h10);
        wr(8'h0e, 8'hf0);
        rchk(8'h0e, 8'h00);
        wr(8'h21, 8'h01);
        wr(8'h0e, 8'h11);
        rchk(8'h0e, 8'h10);
        rchk(8'h12, 8'h00);
        wait_run(1'b0);
        rchk(8'h20, 8'h01);
        chk({7'h00, irq}, 8'h01, "irq after underflow");
        wr(8'h20, 8'h01);
        repeat (3) @(posedge mclk);
        chk({7'h00, irq}, 8'h00, "irq after clear");
        done("one_shot");
        other_active <= 3'b101;
        wr(8'h0e, 8'hee);
        rchk(8'h0e, 8'ha0);
        wr(8'h0e, 8'h11);
        wr(8'h0e, 8'h01);
        rchk(8'h0e, 8'ha0);
        other_active <= 3'b000;
        done("run_control");
        wr(8'h0f, 8'h08);
        wr(8'h11, 8'h03);
        wr(8'h0e, 8'h11);
        repeat (200) @(posedge mclk);
        rchk(8'h0e, 8'h10);
        rchk(8'h20, 8'h01);
        wr(8'h20, 8'h01);
        done("restart");
        wr(8'h21, 8'h00);
        wr(8'h10, 8'hff);
        wr(8'h11, 8'hff);
        pulse(0);
        rchk(8'h0e, 8'h00);
        wr(8'h0f, 8'h90);
        pulse(0);
        rchk(8'h0e, 8'h10);
        pulse(2);
        for (i = 0; i < 3; i++)
            pulse(1);
        rchk(8'h0e, 8'h10);
        pulse(1);
        rchk(8'h0e, 8'h00);
        done("rx_halt");
        wr(8'h0f, 8'ha0);
        @(posedge mclk) osc <= 1'b1;
        repeat (6) @(posedge mclk);
        rchk(8'h0e, 8'h10);
        pulse(2);
        for (i = 0; i < 4; i++)
            pulse(1);
        rchk(8'h0e, 8'h10);
        @(posedge mclk) osc <= 1'b0;
        repeat (6) @(posedge mclk);
        osc <= 1'b1;
        repeat (6) @(posedge mclk);
        rchk(8'h0e, 8'h00);
        osc <= 1'b0;
        done("trimming");
        wr(8'h0f, 8'h02);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h02);
        wr(8'h0e, 8'h11);
        rchk(8'h13, 8'h02);
        pulse(3);
        rchk(8'h13, 8'h02);
        pulse(4);
        rchk(8'h13, 8'h01);
        wr(8'h11, 8'h50);
        wr(8'h10, 8'h01);
        rchk(8'h13, 8'h01);
        wr(8'h0e, 8'h01);
        wr(8'h0f, 8'h03);
        wr(8'h0e, 8'h11);
        rchk(8'h12, 8'h01);
        pulse(3);
        rchk(8'h13, 8'h4f);
        done("cascade");
        // Read windows span whole divider periods, so tick counts are exact
        wr(8'h0f, 8'h00);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h50);
        wr(8'h0e, 8'h11);
        rd(8'h13, v_first);
        repeat (4 * `FAST_TICK_CYCLES - 2) @(posedge mclk);
        rd(8'h13, v_second);
        chk(v_first - v_second, 8'h04, "fast tick rate");
        wr(8'h0e, 8'h01);
        wr(8'h0f, 8'h01);
        wr(8'h0e, 8'h11);
        rd(8'h13, v_first);
        repeat (`SLOW_TICK_CYCLES - 2) @(posedge mclk);
        rd(8'h13, v_second);
        chk(v_first - v_second, 8'h01, "slow tick rate");
        done("tick_rates");
        summarize();
    end
endmodule : timer_section_test
